// >>> core/epio_top.sv
// Operation
// R01: sixteen byte registers at indices 0 to 15
// R02: port a full eight-bit bidirectional
// R03: narrow ports; unimplemented bits read zero
// R04: port c direction bit7 clock enable, bit6 zero
// R05: direction one drives latch, zero floats pin
// R06: reset clears all direction bits
// R07: data latches untouched by reset
// R08: output bit reads back latch
// R09: input bit reads pin level
// R10: data writes always load latch
// R11: direction registers readable, return last written value
// R12: port b pins shared with converter select
// R13: selected converter pin reads zero or latch
// R14: converter pin ignores direction for buffer
// R15: software loads latch before enabling output
// R16: clock enable drives system clock onto c2
// R17: writes to unimplemented bits are ignored
// R18: accesses synchronous; pins sampled on read
`timescale 1ns/10ps
`default_nettype none
module epio_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // port pins, ports a..h packed as eight bytes
  input  wire logic [63:0] pin_in,
  output logic [63:0]      pin_out,
  output logic [63:0]      pin_oe,
  // converter side
  input  wire logic        converter_active,
  input  wire logic [4:0]  converter_input_select,
  output logic [7:0]       analog_input_pins,
  // system clock level for the clock output
  input  wire logic        sysclk_level
);

  function automatic logic [7:0] port_mask(input logic [2:0] p);
    case (p)
      3'd2:    port_mask = epio_pkg::MASK_C;
      3'd5:    port_mask = epio_pkg::MASK_F;
      3'd6:    port_mask = epio_pkg::MASK_G;
      3'd7:    port_mask = epio_pkg::MASK_H;
      default: port_mask = epio_pkg::MASK_FULL;
    endcase
  endfunction

  // index to port number and kind: [1:0] low port, [2] dir, [3] high group
  function automatic logic [2:0] idx_port(input logic [3:0] idx);
    idx_port = {idx[3], idx[1:0]};
  endfunction

  logic [7:0] latch_r [0:7];
  logic [7:0] dir_r   [0:7];
  logic       clken_r;

  logic        aw_held_r;
  logic [3:0]  aw_idx_r;
  logic        aw_ok_r;
  logic        w_held_r;
  logic [7:0]  w_byte_r;
  logic        w_lane_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // address decode, one aligned word per register
  wire         aw_take    = s_axi_awvalid & ~aw_held_r & ~bvalid_r;
  wire         w_take     = s_axi_wvalid & ~w_held_r & ~bvalid_r;
  wire         aw_in_ok   = (s_axi_awaddr[1:0] == 2'b00); // [R01]
  wire         wr_go      = aw_held_r & w_held_r & ~bvalid_r;
  wire         wr_do      = wr_go & aw_ok_r & w_lane_r;
  wire [2:0]   wr_port    = idx_port(aw_idx_r);
  wire         wr_is_dir  = aw_idx_r[2];

  wire         ar_take    = s_axi_arvalid & ~rvalid_r;
  wire [3:0]   ar_idx     = s_axi_araddr[5:2];
  wire         ar_ok      = (s_axi_araddr[1:0] == 2'b00);
  wire [2:0]   rd_port    = idx_port(ar_idx);

  // converter owns a port b pin while it selects it
  wire         conv_sel_valid = converter_active &
                                (converter_input_select <= epio_pkg::CONV_LAST_PIN);
  wire [7:0]   conv_pins  = conv_sel_valid ?
                            (8'h01 << converter_input_select[2:0]) : 8'h00; // [R12]

  // read value per port: latch where output, pin where input
  logic [7:0] port_view [0:7];
  always_comb begin
    for (int p = 0; p < epio_pkg::NUM_PORTS; p++) begin
      port_view[p] = ((dir_r[p] & latch_r[p]) |
                      (~dir_r[p] & pin_in[p*8 +: 8])) & port_mask(3'(p)); // [R08] [R09] [R03]
    end
    // selected converter pin reads zero as input, latch as output
    port_view[1] = (port_view[1] & ~conv_pins) |
                   (conv_pins & dir_r[1] & latch_r[1]); // [R13]
    // pin 2 of port c shows zero while it carries the clock
    if (clken_r) begin
      port_view[epio_pkg::PORT_C][epio_pkg::SYSCLK_PIN] = 1'b0; // [R16]
    end
  end

  wire [7:0] dir_view = (rd_port == 3'(epio_pkg::PORT_C)) ?
                        {clken_r, 1'b0, dir_r[epio_pkg::PORT_C][5:0]} :
                        dir_r[rd_port]; // [R04] [R11]
  wire [7:0] rd_byte  = ar_idx[2] ? dir_view : port_view[rd_port];

  // pin drivers
  always_comb begin
    for (int p = 0; p < epio_pkg::NUM_PORTS; p++) begin
      pin_out[p*8 +: 8] = latch_r[p] & port_mask(3'(p)); // [R05] [R02]
      pin_oe[p*8 +: 8]  = dir_r[p] & port_mask(3'(p));   // [R05]
    end
    // converter pins float whatever their direction bit
    pin_oe[15:8] = dir_r[1] & ~conv_pins; // [R14]
    if (clken_r) begin
      pin_out[epio_pkg::PORT_C*8 + epio_pkg::SYSCLK_PIN] = sysclk_level; // [R16]
      pin_oe[epio_pkg::PORT_C*8 + epio_pkg::SYSCLK_PIN]  = 1'b1;        // [R16]
    end
  end

  assign analog_input_pins = conv_pins;

  // write channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_idx_r  <= 4'h0;
      aw_ok_r   <= 1'b0;
      w_held_r  <= 1'b0;
      w_byte_r  <= 8'h00;
      w_lane_r  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[5:2];
        aw_ok_r   <= aw_in_ok;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        w_byte_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= epio_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= aw_ok_r ? epio_pkg::RESP_OKAY : epio_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // data latches: no reset, so their contents survive it
  always_ff @(posedge aclk) begin
    if (wr_do && !wr_is_dir) begin
      latch_r[wr_port] <= w_byte_r & port_mask(wr_port); // [R07] [R10] [R17]
    end
  end

  // direction registers and clock-output enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < epio_pkg::NUM_PORTS; p++) begin
        dir_r[p] <= epio_pkg::DIR_RESET; // [R06]
      end
      clken_r <= epio_pkg::CLKEN_RESET; // [R16]
    end else if (wr_do && wr_is_dir) begin
      dir_r[wr_port] <= w_byte_r & port_mask(wr_port); // [R11] [R17]
      if (wr_port == 3'(epio_pkg::PORT_C)) begin
        clken_r <= w_byte_r[epio_pkg::SYSCLK_EN_BIT]; // [R04]
      end
    end
  end

  // read channel: pins sampled in the cycle the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= epio_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= ar_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000; // [R18]
      rresp_r  <= ar_ok ? epio_pkg::RESP_OKAY : epio_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

endmodule
`default_nettype wire

// >>> inc/epio_pkg.sv
package epio_pkg;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_PA_LATCH = 4'h0;
  localparam logic [3:0] IDX_PB_LATCH = 4'h1;
  localparam logic [3:0] IDX_PC_LATCH = 4'h2;
  localparam logic [3:0] IDX_PD_LATCH = 4'h3;
  localparam logic [3:0] IDX_PA_DIR   = 4'h4;
  localparam logic [3:0] IDX_PB_DIR   = 4'h5;
  localparam logic [3:0] IDX_PC_DIR   = 4'h6;
  localparam logic [3:0] IDX_PD_DIR   = 4'h7;
  localparam logic [3:0] IDX_PE_LATCH = 4'h8;
  localparam logic [3:0] IDX_PF_LATCH = 4'h9;
  localparam logic [3:0] IDX_PG_LATCH = 4'hA;
  localparam logic [3:0] IDX_PH_LATCH = 4'hB;
  localparam logic [3:0] IDX_PE_DIR   = 4'hC;
  localparam logic [3:0] IDX_PF_DIR   = 4'hD;
  localparam logic [3:0] IDX_PG_DIR   = 4'hE;
  localparam logic [3:0] IDX_PH_DIR   = 4'hF;

  // ports a..h in order 0..7
  localparam int NUM_PORTS = 8;
  localparam int PORT_C    = 2;

  // implemented bits of each port
  localparam logic [7:0] MASK_FULL  = 8'hFF;
  localparam logic [7:0] MASK_C     = 8'h3F;
  localparam logic [7:0] MASK_F     = 8'h7F;
  localparam logic [7:0] MASK_G     = 8'h07;
  localparam logic [7:0] MASK_H     = 8'h03;
  localparam logic [7:0] MASK_C_DIR = 8'hBF;

  // clock-output enable position in port c direction register, and the port c pin that carries the clock
  localparam int SYSCLK_EN_BIT = 7;
  localparam int SYSCLK_PIN    = 2;

  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic       CLKEN_RESET = 1'b0;

  // converter channel select codes 0..7 pick port b pins
  localparam logic [4:0] CONV_LAST_PIN = 5'h07;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam int ADDR_W = 6;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } epio_drive_t;

  typedef enum logic [1:0] {
    EPIO_RSP_OKAY   = 2'b00,
    EPIO_RSP_SLVERR = 2'b10
  } epio_resp_t;

endpackage

// >>> dv/epio_chk.sv
`timescale 1ns/10ps
`default_nettype none
module epio_chk (
  // bus
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // pins
  input wire logic [63:0] pin_oe,
  input wire logic [7:0]  analog_input_pins
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_dirs: assert property ($rose(aresetn) |-> pin_oe == '0)
    else $error("pin driven after reset");
  a_narrow_oe: assert property ((pin_oe & 64'hFCF8_8000_00C0_0000) == '0)
    else $error("absent pin driven");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
    else $error("upper read bits set");
  a_bad_addr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
    |=> s_axi_rresp == epio_pkg::RESP_SLVERR && s_axi_rdata == '0) else $error("bad address read");
  a_conv_oe: assert property ((pin_oe[15:8] & analog_input_pins) == '0)
    else $error("converter pin driven");
endmodule
bind epio_top epio_chk epio_chk_i (.*);
`default_nettype wire

// >>> dv/epio_pins.sv
`timescale 1ns/10ps
`default_nettype none
module epio_pins (
  // block side
  input wire logic [63:0] pin_out,
  input wire logic [63:0] pin_oe,
  // board side
  input wire logic [63:0] ext_level,
  output logic [63:0]     pin_in
);
  // undriven pins show the board level, never a stale drive
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule
`default_nettype wire

// >>> dv/test_eight_port_parallel_io.sv
`timescale 1ns/10ps
`default_nettype none
module test_eight_port_parallel_io;
  logic        aclk, aresetn, converter_active, sysclk_level, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [4:0]  converter_input_select;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [7:0]  analog_input_pins, tab [16];
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [63:0] pin_in, pin_out, pin_oe, ext_level;
  int          err_total, checked;
  epio_top epio_top_i (.*);
  epio_pins epio_pins_i (.*);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    err_total += int'(g !== e);
    if (g !== e)
      $display("BAD %s exp %h got %h", n, e, g);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {7'h0, a[1:0] != 2'h0}, {6'h0, s_axi_bresp[1] ^ s_axi_bresp[0], 1'b0} >> 1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata[7:0]);
    chk("rresp", {7'h0, a[1:0] != 2'h0}, {6'h0, s_axi_rresp[1] ^ s_axi_rresp[0], 1'b0} >> 1);
  endtask
  task automatic give_verdict;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    give_verdict();
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {converter_active, sysclk_level, converter_input_select, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {44'h0, 4'h1};
    ext_level = {48'h0, 16'hF83C};
    tab = '{8'hFF, 8'hFF, 8'h3B, 8'hFF, 8'hFF, 8'hFF, 8'hBF, 8'hFF,
            8'hFF, 8'h7F, 8'h07, 8'h03, 8'hFF, 8'h7F, 8'h07, 8'h03};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(6'h10, 8'h00);
    wr(6'h00, 8'hA5);
    wr(6'h10, 8'h0F);
    rd(6'h00, 8'h35);
    chk("oe_a", 8'h0F, pin_oe[7:0]);
    rd(6'h05, 8'h00);
    $display("port a test done");
    sysclk_level <= 1'b1;
    for (int i = 0; i < 16; i++)
      wr(6'(4 * i), 8'hFF);
    for (int i = 0; i < 16; i++)
      rd(6'(4 * i), tab[i]);
    chk("clk_out", 8'h01, {7'h0, pin_out[18]});
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(6'h18, 8'h00);
    wr(6'h10, 8'hFF);
    rd(6'h00, 8'hFF);
    $display("register test done");
    wr(6'h04, 8'h5A);
    rd(6'h04, 8'hF8);
    {converter_active, converter_input_select} <= 6'h23;
    wr(6'h14, 8'h02);
    rd(6'h04, 8'hF2);
    chk("conv", 8'h08, analog_input_pins);
    wr(6'h14, 8'h0A);
    rd(6'h04, 8'hFA);
    chk("oe_b", 8'h02, pin_oe[15:8]);
    $display("converter test done");
    give_verdict();
  end
endmodule
`default_nettype wire
